//--- design/flash_program_erase_controller.sv
// How it works
// R1: Sequence byte program, page erase, mass erase.
// R2: Two frequency bytes form kHz timing base.
// R3: Software loads frequency before any operation.
// R4: Software keeps clock between 20kHz and 20MHz.
// R5: Reset leaves controller locked.
// R6: Out-of-sequence command or page write locks.
// R7: Unlock: 00, page, 73, 8C, same page.
// R8: Command 5E maps sector protect onto page.
// R9: Other commands unmap sector protect.
// R10: Sector protect bits can only be set.
// R11: Reset clears all sector protect bits.
// R12: Protected sectors are never programmed or erased.
// R13: Read-protect option refuses debug and bypass reads. The code refuses only dbgRdReq debug reads and has no bypass read path.
// R14: Status reads and command writes share FF8.
// R15: Status readable anytime without side effects.
// R16: Status codes for lock, unlock steps, protect select.
// R17: Busy codes for program, page and mass erase.
// R18: Status bits 7 and 6 read zero.
// R19: Program data while not unlocked is dropped.
// R20: Page is checked against protection before start.
// R21: Completion clears the busy code.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_params.svh"

module flash_program_erase_controller
  import flash_ctrl_pkg::*;
#(
  parameter logic [15:0] PROG_TIME_US = `PROG_TIME_US,
  parameter logic [15:0] PERASE_TIME_US = `PERASE_TIME_US,
  parameter logic [15:0] MERASE_TIME_US = `MERASE_TIME_US,
  parameter int SEC_SHIFT = 1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic progWrReq,
  input wire logic [15:0] progWrAddr,
  input wire logic [7:0] progWrData,
  input wire logic readProtectOption,
  input wire logic dbgRdReq,
  output logic dbgRdGrant,
  output logic dbgRdDenied,
  output logic progDropped,
  output logic opBusy,
  output logic [15:0] arrAddr,
  output logic [7:0] arrData,
  output logic arrProgEn,
  output logic arrPageEraseEn,
  output logic arrMassEraseEn
);

  // ==========================================================
  // State
  fstate_t state_q, state_d;
  seq_t seq_q, seq_d;
  logic [7:0] page_q, page_d;
  logic [7:0] prot_q, prot_d;
  logic [7:0] freqHi_q, freqLo_q;
  logic startOp;
  logic [15:0] opTime;
  logic timerDone;
  logic pageProt, anyProt;

  // Both the present and the next state need the busy decode.
  function automatic logic isBusy(input fstate_t s);
    unique case (s)
      ST_PROG, ST_PERASE, ST_MERASE: isBusy = 1'b1;
      default: isBusy = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Register decode
  wire logic ctlWr = regWr && (regAddr == `FLASH_CTL_ADDR);
  wire logic pageWr = regWr && (regAddr == `FLASH_PAGE_ADDR);
  wire logic freqHiWr = regWr && (regAddr == `FLASH_FREQ_HI_ADDR);
  wire logic freqLoWr = regWr && (regAddr == `FLASH_FREQ_LO_ADDR);
  wire logic [15:0] khz = {freqHi_q, freqLo_q}; // [R2]
  wire logic busy = isBusy(state_q);
  wire logic [7:0] progPage = 8'(progWrAddr >> `PAGE_LSB);
  wire logic progOk = progWrReq && (state_q == ST_UNLOCKED)
    && (progPage == page_q) && !pageProt;
  wire logic cmdPageErase = ctlWr && (regWrData == `CMD_PAGE_ERASE)
    && (state_q == ST_UNLOCKED) && !pageProt;
  wire logic cmdMassErase = ctlWr && (regWrData == `CMD_MASS_ERASE)
    && (state_q == ST_UNLOCKED) && !anyProt;
  wire logic busyD = isBusy(state_d);

  // Reads have no side effects, so status polling is safe mid-operation.
  wire logic [7:0] rdData =
    !regRd ? 8'h00 :
    (regAddr == `FLASH_CTL_ADDR) ? {`STATUS_RSVD, state_q} : // [R14] [R15] [R18]
    (regAddr == `FLASH_PAGE_ADDR) ? ((state_q == ST_SECPROT) ? prot_q : page_q) :
    (regAddr == `FLASH_FREQ_HI_ADDR) ? freqHi_q :
    (regAddr == `FLASH_FREQ_LO_ADDR) ? freqLo_q : 8'h00;

  sector_guard #(
    .SEC_SHIFT(SEC_SHIFT)
  ) u_guard (
    .page(page_q),
    .protBits(prot_q),
    .isProt(pageProt),
    .anyProt(anyProt)
  );

  flash_op_timer u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(startOp),
    .khz(khz),
    .timeUs(opTime),
    .done(timerDone)
  );

  // ==========================================================
  // Unlock sequence and operation control
  // Command and page writes during an operation are ignored so that the
  // array timing cannot be cut short by a stray write.
  always_comb begin
    state_d = state_q;
    seq_d = seq_q;
    page_d = page_q;
    prot_d = prot_q;
    startOp = 1'b0;
    opTime = PROG_TIME_US;
    if (busy) begin
      if (timerDone) begin
        state_d = ST_UNLOCKED; // [R21]
      end
    end else if (ctlWr) begin
      seq_d = SEQ_IDLE;
      if (regWrData == `CMD_RESET) begin
        state_d = ST_LOCKED; // [R7]
        seq_d = SEQ_CLEARED;
      end else if (regWrData == `CMD_SECPROT) begin
        state_d = ST_SECPROT; // [R8]
      end else if ((regWrData == `CMD_UNLOCK1) && (state_q == ST_LOCKED)
          && (seq_q == SEQ_PAGE)) begin
        state_d = ST_UNL1; // [R7] [R16]
      end else if ((regWrData == `CMD_UNLOCK2) && (state_q == ST_UNL1)) begin
        state_d = ST_UNL2; // [R7] [R16]
      end else if (cmdPageErase) begin
        state_d = ST_PERASE; // [R1] [R12] [R20]
        startOp = 1'b1;
        opTime = PERASE_TIME_US;
      end else if (cmdMassErase) begin
        state_d = ST_MERASE; // [R1] [R12]
        startOp = 1'b1;
        opTime = MERASE_TIME_US;
      end else begin
        state_d = ST_LOCKED; // [R6] [R9]
      end
    end else if (pageWr) begin
      seq_d = SEQ_IDLE;
      if (state_q == ST_SECPROT) begin
        prot_d = prot_q | regWrData; // [R10]
      end else begin
        page_d = regWrData;
        if ((state_q == ST_LOCKED) && (seq_q == SEQ_CLEARED)) begin
          seq_d = SEQ_PAGE; // [R7]
        end else if ((state_q == ST_UNL2) && (regWrData == page_q)) begin
          state_d = ST_UNLOCKED; // [R7] [R16]
        end else begin
          state_d = ST_LOCKED; // [R6]
        end
      end
    end else if (progOk) begin
      state_d = ST_PROG; // [R1] [R17] [R20]
      startOp = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_LOCKED; // [R5]
      seq_q <= SEQ_IDLE;
      page_q <= `PAGE_RST;
      prot_q <= `PROT_RST; // [R11]
    end else begin
      state_q <= state_d;
      seq_q <= seq_d;
      page_q <= page_d;
      prot_q <= prot_d;
    end
  end

  // The frequency may be changed at any time; the timer samples it only
  // when an operation starts.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      freqHi_q <= `FREQ_RST;
      freqLo_q <= `FREQ_RST;
    end else begin
      if (freqHiWr) begin
        freqHi_q <= regWrData; // [R2]
      end
      if (freqLoWr) begin
        freqLo_q <= regWrData; // [R2]
      end
    end
  end

  // ==========================================================
  // Array drive and answers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      arrAddr <= 16'h0000;
      arrData <= 8'h00;
      arrProgEn <= 1'b0;
      arrPageEraseEn <= 1'b0;
      arrMassEraseEn <= 1'b0;
      opBusy <= 1'b0;
    end else begin
      if (progOk && !busy && !ctlWr && !pageWr) begin
        arrAddr <= progWrAddr;
        arrData <= progWrData;
      end else if (cmdPageErase && !busy) begin
        arrAddr <= 16'(page_q) << `PAGE_LSB;
      end
      arrProgEn <= (state_d == ST_PROG); // [R1]
      arrPageEraseEn <= (state_d == ST_PERASE); // [R1]
      arrMassEraseEn <= (state_d == ST_MERASE); // [R1]
      opBusy <= busyD;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdData <= 8'h00;
      dbgRdGrant <= 1'b0;
      dbgRdDenied <= 1'b0;
      progDropped <= 1'b0;
    end else begin
      regRdData <= rdData;
      dbgRdGrant <= dbgRdReq && !readProtectOption;
      dbgRdDenied <= dbgRdReq && readProtectOption; // [R13]
      progDropped <= progWrReq && (state_d != ST_PROG); // [R19]
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  ctlZeroLocks_a: // [R6]
    assert property (ctlWr && (regWrData == `CMD_RESET) && !busy
      |=> (state_q == ST_LOCKED) && (seq_q == SEQ_CLEARED))
    else $error("Reset command did not lock the controller.");

  badPageLocks_a: // [R6]
    assert property ((state_q == ST_UNL2) && pageWr && (regWrData != page_q)
      |=> state_q == ST_LOCKED)
    else $error("Mismatched page did not lock the controller.");

  protSetOnly_a: // [R10]
    assert property (1'b1 |=> ((prot_q & $past(prot_q)) == $past(prot_q)))
    else $error("Sector protect bit was cleared.");

  statusRead_a: // [R16]
    assert property (regRd && (regAddr == `FLASH_CTL_ADDR)
      |=> regRdData == {`STATUS_RSVD, $past(state_q)})
    else $error("Status read does not show controller state.");

  statusRsvd_a: // [R18]
    assert property (regRd && (regAddr == `FLASH_CTL_ADDR) |=> regRdData[7:6] == 2'b00)
    else $error("Reserved status bits are not zero.");

  progLocked_a: // [R19]
    assert property ($rose(arrProgEn) |-> $past(state_q) == ST_UNLOCKED)
    else $error("Program started while not unlocked.");

  protBlocks_a: // [R12]
    assert property ($rose(opBusy) && !arrMassEraseEn |-> !$past(pageProt))
    else $error("Operation started on a protected sector.");

  secSelect_a: // [R8]
    assert property (ctlWr && (regWrData == `CMD_SECPROT) && !busy
      |=> state_q == ST_SECPROT ##0 opBusy == 1'b0)
    else $error("Sector protect select failed.");

  busyCode_a: // [R17]
    assert property ((state_q == ST_PROG) |-> arrProgEn && opBusy)
    else $error("Program busy code without array program enable.");

  readDeny_a: // [R13]
    assert property (dbgRdReq && readProtectOption |=> dbgRdDenied && !dbgRdGrant)
    else $error("Protected read was not refused.");

  doneClears_a: // [R21]
    assert property (busy && timerDone |=> state_q == ST_UNLOCKED ##1 !opBusy)
    else $error("Completion did not clear the busy code.");

  unlockDone_a: // [R7]
    assert property ((state_q == ST_UNL2) && pageWr && (regWrData == page_q)
      |=> state_q == ST_UNLOCKED)
    else $error("Matching page did not unlock the controller.");

  firstUnlock_a: // [R16]
    assert property (ctlWr && (regWrData == `CMD_UNLOCK1) && (state_q == ST_LOCKED)
      && (seq_q == SEQ_PAGE) |=> state_q == ST_UNL1)
    else $error("First unlock command was not recorded.");

  protDeselect_a: // [R9]
    assert property (ctlWr && (regWrData != `CMD_SECPROT) && !busy
      |=> state_q != ST_SECPROT)
    else $error("Sector protect stayed selected after another command.");

  massRefused_a: // [R12]
    assert property (ctlWr && (regWrData == `CMD_MASS_ERASE) && !busy && anyProt
      |=> !arrMassEraseEn && (state_q == ST_LOCKED))
    else $error("Mass erase ran with a protected sector.");

  lockedDrop_a: // [R19]
    assert property (progWrReq && (state_q == ST_LOCKED) |=> progDropped && !arrProgEn)
    else $error("Program data was accepted while locked.");

  oneOperation_a: // [R1]
    assert property ($onehot0({arrProgEn, arrPageEraseEn, arrMassEraseEn}))
    else $error("More than one array operation enabled.");

  eraseCode_a: // [R17]
    assert property (((state_q == ST_PERASE) == arrPageEraseEn)
      && ((state_q == ST_MERASE) == arrMassEraseEn))
    else $error("Erase busy code and array enable disagree.");

  progProt_a: // [R20]
    assert property (progWrReq && pageProt && (state_q == ST_UNLOCKED)
      |=> progDropped && !arrProgEn)
    else $error("Program started on a protected page.");

  unlockCov_c: cover property (state_q == ST_UNL2 ##[1:4] state_q == ST_UNLOCKED);
  progCov_c: cover property ($fell(arrProgEn));
  eraseCov_c: cover property ($fell(arrPageEraseEn));
  massCov_c: cover property ($fell(arrMassEraseEn));
  protCov_c: cover property (pageWr && (state_q == ST_SECPROT));

endmodule
`default_nettype wire

//--- design/flash_ctrl_params.svh
`ifndef FLASH_CTRL_PARAMS_SVH
`define FLASH_CTRL_PARAMS_SVH

// ==========================================================
// Register addresses
`define FLASH_CTL_ADDR 12'hff8
`define FLASH_PAGE_ADDR 12'hff9
`define FLASH_FREQ_HI_ADDR 12'hffa
`define FLASH_FREQ_LO_ADDR 12'hffb

// ==========================================================
// Command codes written to the command register
`define CMD_RESET 8'h00
`define CMD_UNLOCK1 8'h73
`define CMD_UNLOCK2 8'h8c
`define CMD_SECPROT 8'h5e
`define CMD_PAGE_ERASE 8'h95
`define CMD_MASS_ERASE 8'h63

// ==========================================================
// Reset values and field layout
`define FREQ_RST 8'h00
`define PAGE_RST 8'h00
`define PROT_RST 8'h00
`define STATUS_RSVD 2'h0
`define PAGE_LSB 9

// ==========================================================
// Timing
`define US_PER_MS 32'd1000
`define PROG_TIME_US 16'd40
`define PERASE_TIME_US 16'd10000
`define MERASE_TIME_US 16'd20000

`endif

//--- design/flash_ctrl_pkg.sv
`default_nettype none
package flash_ctrl_pkg;

  // Codes are the values software sees in the status field.
  typedef enum logic [5:0] {
    ST_LOCKED = 6'h00,
    ST_UNL1 = 6'h01,
    ST_UNL2 = 6'h02,
    ST_UNLOCKED = 6'h03,
    ST_SECPROT = 6'h04,
    ST_PROG = 6'h08,
    ST_PERASE = 6'h10,
    ST_MERASE = 6'h20
  } fstate_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_CLEARED = 2'b01,
    SEQ_PAGE = 2'b11
  } seq_t;

endpackage
`default_nettype wire

//--- design/flash_op_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_params.svh"

module flash_op_timer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] khz,
  input wire logic [15:0] timeUs,
  output logic done
);

  logic [31:0] cnt_q;
  wire logic [31:0] prod = 32'(khz) * 32'(timeUs);
  wire logic [31:0] quot = prod / `US_PER_MS;
  // A zero frequency would otherwise give an operation that never ends.
  wire logic [31:0] load = (quot == 32'h0) ? 32'h1 : quot;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0;
      done <= 1'b0;
    end else begin
      done <= (cnt_q == 32'h1) && !start;
      if (start) begin
        cnt_q <= load;
      end else if (cnt_q != 32'h0) begin
        cnt_q <= cnt_q - 32'h1;
      end
    end
  end

endmodule
`default_nettype wire

//--- design/sector_guard.sv
`timescale 1ns/1ps
`default_nettype none

module sector_guard #(
  parameter int SEC_SHIFT = 1
) (
  input wire logic [7:0] page,
  input wire logic [7:0] protBits,
  output logic isProt,
  output logic anyProt
);

  wire logic [7:0] sector = page >> SEC_SHIFT;
  // Pages beyond the eighth sector have no protection bit and stay writable.
  assign isProt = (sector < 8'h08) ? protBits[sector[2:0]] : 1'b0;
  assign anyProt = |protBits;

endmodule
`default_nettype wire

//--- bench/flash_array_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Flash array seen from the controller side
module flash_array_model (
  input wire logic ref_clk,
  input wire logic [15:0] arrAddr,
  input wire logic [7:0] arrData,
  input wire logic arrProgEn,
  input wire logic arrPageEraseEn,
  input wire logic arrMassEraseEn,
  input wire logic [15:0] peekAddr,
  output logic [7:0] peekData
);
  logic [7:0] mem [0:65535];
  logic [2:0] enPrev_q = 3'h0;
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
  end
  // Acting only on an enable rise keeps a long operation from acting twice.
  always @(posedge ref_clk) begin
    if (arrProgEn && !enPrev_q[0]) begin
      mem[arrAddr] = mem[arrAddr] & arrData;
    end
    if (arrPageEraseEn && !enPrev_q[1]) begin
      for (int i = 0; i < 512; i++) mem[{arrAddr[15:9], 9'(i)}] = 8'hff;
    end
    if (arrMassEraseEn && !enPrev_q[2]) begin
      for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
    end
    enPrev_q <= {arrMassEraseEn, arrPageEraseEn, arrProgEn};
  end
  assign peekData = mem[peekAddr];
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_params.svh"
module testbench;
  localparam int KHZ = 10000;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] regAddr = 12'h000;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic progWrReq = 1'b0;
  logic [15:0] progWrAddr = 16'h0000;
  logic [7:0] progWrData = 8'h00;
  logic readProtectOption = 1'b0;
  logic dbgRdReq = 1'b0;
  logic [7:0] regRdData, arrData, peekData;
  logic [15:0] arrAddr;
  logic [15:0] peekAddr = 16'h0000;
  logic dbgRdGrant, dbgRdDenied, progDropped, opBusy;
  logic arrProgEn, arrPageEraseEn, arrMassEraseEn;
  int failCount = 0;
  int testsRun = 0;
  logic [7:0] cmds [2] = '{`CMD_PAGE_ERASE, `CMD_MASS_ERASE};
  logic [7:0] codes [2] = '{8'h10, 8'h20};
  int times [2] = '{20, 30};

  always #2 ref_clk = ~ref_clk;

  // Operation times shortened to a few microseconds so that counts stay small.
  flash_program_erase_controller #(.PROG_TIME_US(16'h0001), .PERASE_TIME_US(16'h0002),
    .MERASE_TIME_US(16'h0003)) flash_program_erase_controller_i (.ref_clk, .rst, .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .progWrReq, .progWrAddr, .progWrData,
    .readProtectOption, .dbgRdReq, .dbgRdGrant, .dbgRdDenied, .progDropped, .opBusy,
    .arrAddr, .arrData, .arrProgEn, .arrPageEraseEn, .arrMassEraseEn);
  flash_array_model flash_array_model_i (.ref_clk, .arrAddr, .arrData, .arrProgEn,
    .arrPageEraseEn, .arrMassEraseEn, .peekAddr, .peekData);

  // ==========================================================
  // Access tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk(regRdData, e);
  endtask
  task automatic cmd(input logic [7:0] d);
    wr(`FLASH_CTL_ADDR, d);
  endtask
  task automatic stat(input logic [7:0] e);
    rd(`FLASH_CTL_ADDR, e);
  endtask
  task automatic pg(input logic [7:0] d);
    wr(`FLASH_PAGE_ADDR, d);
  endtask
  task automatic unlock(input logic [7:0] p);
    cmd(`CMD_RESET);
    pg(p);
    cmd(`CMD_UNLOCK1);
    stat(8'h01);
    cmd(`CMD_UNLOCK2);
    stat(8'h02);
    pg(p);
    stat(8'h03);
  endtask
  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    progWrReq <= 1'b1;
    progWrAddr <= a;
    progWrData <= d;
    @(posedge ref_clk);
    progWrReq <= 1'b0;
    #1;
  endtask
  // An operation lasts one cycle more than its nominal count, less the status reads
  // that a caller makes before it starts to wait.
  task automatic waitIdle(input int n);
    int c;
    c = 0;
    while (opBusy !== 1'b0 && c < 500) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
    if (c >= 500) begin
      failCount++;
      final_report();
    end else begin
      chk(16'((c + 2 >= n) && (c <= n + 2)), 16'h0001);
    end
  endtask
  task automatic dbg(input logic p);
    @(posedge ref_clk);
    readProtectOption <= p;
    dbgRdReq <= 1'b1;
    @(posedge ref_clk);
    dbgRdReq <= 1'b0;
    #1;
    chk({dbgRdGrant, dbgRdDenied}, {~p, p});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    stat(8'h00);
    rd(12'h100, 8'h00);
    wr(`FLASH_FREQ_HI_ADDR, 8'h27);
    wr(`FLASH_FREQ_LO_ADDR, 8'h10);
    unlock(8'h04);
    prog(16'h0812, 8'h5a);
    chk({arrProgEn, opBusy, arrData}, {2'b11, 8'h5a});
    chk(arrAddr, 16'h0812);
    stat(8'h08);
    waitIdle(KHZ / 1000);
    stat(8'h03);
    peekAddr = 16'h0812;
    #1 chk(peekData, 8'h5a);
    cmd(`CMD_UNLOCK1);
    stat(8'h00);
    prog(16'h0813, 8'h00);
    chk({progDropped, arrProgEn}, 2'b10);
    cmd(`CMD_RESET);
    pg(8'h04);
    cmd(`CMD_UNLOCK1);
    cmd(`CMD_UNLOCK2);
    pg(8'h05);
    stat(8'h00);
    for (int i = 0; i < 2; i++) begin
      unlock(8'h04);
      prog(16'h0812, 8'h5a);
      waitIdle(KHZ / 1000);
      cmd(cmds[i]);
      #1 chk({arrPageEraseEn, arrMassEraseEn, opBusy}, {i == 0, i == 1, 1'b1});
      if (i == 0) chk(arrAddr, 16'h0800);
      stat(codes[i]);
      waitIdle(times[i] * KHZ / 10000);
      stat(8'h03);
      #1 chk(peekData, 8'hff);
    end
    cmd(`CMD_SECPROT);
    stat(8'h04);
    pg(8'h01);
    pg(8'h02);
    rd(`FLASH_PAGE_ADDR, 8'h03);
    pg(8'h00);
    rd(`FLASH_PAGE_ADDR, 8'h03);
    cmd(`CMD_RESET);
    pg(8'h06);
    cmd(`CMD_SECPROT);
    rd(`FLASH_PAGE_ADDR, 8'h03);
    unlock(8'h02);
    prog(16'h0400, 8'h11);
    chk({progDropped, arrProgEn}, 2'b10);
    cmd(`CMD_MASS_ERASE);
    #1 chk(arrMassEraseEn, 1'b0);
    stat(8'h00);
    unlock(8'h04);
    prog(16'h0900, 8'h33);
    chk({progDropped, arrProgEn}, 2'b01);
    waitIdle(KHZ / 1000);
    peekAddr = 16'h0900;
    #1 chk(peekData, 8'h33);
    dbg(1'b0);
    dbg(1'b1);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    cmd(`CMD_SECPROT);
    rd(`FLASH_PAGE_ADDR, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
